// ===== core/csp_defines.vh
// Register indices, field positions, reset values and modes of the serial port
`ifndef CSP_DEFINES_VH
`define CSP_DEFINES_VH

// Register indices; the byte address is four times the index
`define CSP_IDX_CTRL 16'hFF70
`define CSP_IDX_MODE 16'hFF71
`define CSP_IDX_DATA_LO 16'hFF72
`define CSP_IDX_DATA_HI 16'hFF73
`define CSP_IDX_IRQ_MASK 16'hFFE3
`define CSP_IDX_IRQ_FACTOR 16'hFFF3

// Field positions
`define CSP_CTRL_ENABLE 0
`define CSP_CTRL_TRIGGER 1
`define CSP_MODE_CSRC_LO 0
`define CSP_MODE_CSRC_HI 1
`define CSP_MODE_SAMPLE_EDGE 2
`define CSP_MODE_BIT_ORDER 3

// Reset values
`define CSP_RST_CSRC 2'h0
`define CSP_RST_FLAG 1'h0

// Clock source encodings
`define CSP_CSRC_SLAVE 2'h0
`define CSP_CSRC_TIMER 2'h1
`define CSP_CSRC_OSC_HALF 2'h2
`define CSP_CSRC_OSC 2'h3

// Bits per transfer and low-speed oscillator figures
`define CSP_BITS 4'h8
`define CSP_CLK_HZ 125000000
`define CSP_OSC_HZ 32768

`endif

// ===== core/csp_sync.v
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module csp_sync #(
  parameter W = 2
) (
  input wire clk_i,
  input wire reset_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // First stage is read only by the second stage
  always @(posedge clk_i) begin
    if (reset_i) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule // csp_sync
`default_nettype wire

// ===== core/csp_div.v
// Divider that gives a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
`default_nettype none
module csp_div #(
  parameter DIV = 1907
) (
  input wire clk_i,
  input wire reset_i,
  output wire tick_o
);
  localparam [31:0] LAST_W = DIV - 1;
  // Counter is 16 bits wide, so the terminal count is cut to match on purpose
  localparam [15:0] LAST = LAST_W[15:0];
  reg [15:0] cnt_ff;
  reg tick_ff;

  // Free running count; pulse on wrap
  always @(posedge clk_i) begin
    if (reset_i) begin
      cnt_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else if (cnt_ff == LAST) begin
      cnt_ff <= 16'h0000;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
      tick_ff <= 1'b0;
    end
  end

  assign tick_o = tick_ff;
endmodule // csp_div
`default_nettype wire

// ===== core/csp_core.v
// Clocked serial port core with classic Wishbone register access
//
// Behaviour
// R1: Writing one to trigger starts the serial clock transfer; zero does nothing.
// R2: Software accesses data registers and enables the port before triggering.
// R3: Software triggers once per run; repeated triggers while running are forbidden.
// R4: External partner supplies clock pulses only after the trigger.
// R5: Trigger bit reads one while running until eight clocks end; writes ignored.
// R6: Reset clears the run status latch, serial clock stopped.
// R7: Data register bits go out on the serial output pin, one high.
// R8: Serial input bits are assembled and loaded into the data registers.
// R9: Software touches data registers only while the port is stopped.
// R10: Data registers are not reset; their content is undefined after reset.
// R11: Mask bit enables the interrupt at one, readable, reset to zero.
// R12: Factor flag sets at the end of every 8-bit transfer, mask regardless.
// R13: Writing one clears the factor flag, zero leaves it; reset clears.
// R14: Request stays presented while factor set and mask enabled.
// R15: Service routine clears the factor before re-enabling interrupts.
// R16: Software selects bit order before loading data.
// R17: Serial clock stays at or below 1 MHz in slave or timer mode.
// R18: Enable bit hands four pins to the port; ready used in slave mode.
// R19: Clock source: 11 osc, 10 osc/2, 01 timer/2, 00 external slave.
// R20: Bit order select: one MSB first, zero LSB first; reset zero.
// R21: Output changes on the lead edge; sample edge chosen by phase bit.
// R22: Eight-bit shift register and bit counter end transfer after eighth bit.
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "csp_defines.vh"
module csp_core #(
  parameter CLK_POS_POLARITY = 0,
  parameter OSC_HALF_DIV = `CSP_CLK_HZ / (2 * `CSP_OSC_HZ)
) (
  input wire clk_i,
  input wire reset_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [17:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output wire [31:0] dat_o,
  output wire ack_o,
  input wire timer_underflow_i,
  input wire serial_in_pin_i,
  output wire serial_out_pin_o,
  input wire sclk_i,
  output wire sclk_o,
  output wire sclk_oe_o,
  output wire slave_ready_n_o,
  output wire port_function_enable_o,
  output wire serial_irq_o
);
  // Idle level of the serial clock; negative polarity idles high
  localparam IDLE_LVL = (CLK_POS_POLARITY != 0) ? 1'b0 : 1'b1;

  reg ack_ff;
  reg [31:0] rdata_ff;
  reg enable_ff;
  reg run_ff;
  reg [1:0] csrc_ff;
  reg sample_edge_ff;
  reg bit_order_ff;
  reg mask_ff;
  reg factor_ff;
  reg [7:0] data_ff;
  reg [7:0] rx_ff;
  reg [3:0] cnt_ff;
  reg mlvl_ff;
  reg lvl_d_ff;
  reg half_ff;
  reg serial_out_pin_ff;
  reg [31:0] nxt_rdata;

  wire [1:0] pins_s;
  wire osc_tick;
  wire [15:0] idx;
  wire req;
  wire wr;
  wire master;
  wire lvl;
  wire lead;
  wire trail;
  wire samp;
  wire last;
  wire trig;
  wire tick;

  // Pin inputs cross into the clock domain before any logic reads them
  csp_sync #(
    .W(2)
  ) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i({sclk_i, serial_in_pin_i}),
    .sync_o(pins_s)
  );

  // Half-period pulse of the low-speed oscillator
  csp_div #(
    .DIV(OSC_HALF_DIV)
  ) u_div (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tick_o(osc_tick)
  );

  // Bit index of the outgoing bit for the current count
  function [2:0] bit_idx;
    input msb_first;
    input [3:0] cnt;
    begin
      if (msb_first) begin
        bit_idx = 3'h7 - cnt[2:0];
      end else begin
        bit_idx = cnt[2:0];
      end
    end
  endfunction

  // Bus decode; a write takes effect on the edge that samples ack high
  assign idx = adr_i[17:2];
  assign req = cyc_i & stb_i;
  assign wr = req & we_i & ack_ff & sel_i[0];

  // Read mux; unmapped addresses read as zero
  always @* begin
    nxt_rdata = 32'h00000000;
    if (idx == `CSP_IDX_CTRL) begin
      nxt_rdata[`CSP_CTRL_ENABLE] = enable_ff;
      nxt_rdata[`CSP_CTRL_TRIGGER] = run_ff; // R5
    end else if (idx == `CSP_IDX_MODE) begin
      nxt_rdata[`CSP_MODE_CSRC_HI:`CSP_MODE_CSRC_LO] = csrc_ff;
      nxt_rdata[`CSP_MODE_SAMPLE_EDGE] = sample_edge_ff;
      nxt_rdata[`CSP_MODE_BIT_ORDER] = bit_order_ff;
    end else if (idx == `CSP_IDX_DATA_LO) begin
      nxt_rdata[3:0] = data_ff[3:0]; // R8
    end else if (idx == `CSP_IDX_DATA_HI) begin
      nxt_rdata[3:0] = data_ff[7:4]; // R8
    end else if (idx == `CSP_IDX_IRQ_MASK) begin
      nxt_rdata[0] = mask_ff; // R11
    end else if (idx == `CSP_IDX_IRQ_FACTOR) begin
      nxt_rdata[0] = factor_ff;
    end
  end

  // One-cycle ack per request; drops in the cycle after it is given
  always @(posedge clk_i) begin
    if (reset_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= req & ~ack_ff;
      if (req & ~ack_ff) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign dat_o = rdata_ff;
  assign ack_o = ack_ff;

  // Trigger only counts with the port enabled and stopped
  assign trig = wr & (idx == `CSP_IDX_CTRL) & dat_i[`CSP_CTRL_TRIGGER]
    & enable_ff & ~run_ff; // R1

  // Control and mode registers
  always @(posedge clk_i) begin
    if (reset_i) begin
      enable_ff <= 1'b0; // R18
      csrc_ff <= `CSP_RST_CSRC; // R19
      sample_edge_ff <= 1'b0; // R21
      bit_order_ff <= 1'b0; // R20
      mask_ff <= 1'b0; // R11
    end else if (wr) begin
      if (idx == `CSP_IDX_CTRL) begin
        enable_ff <= dat_i[`CSP_CTRL_ENABLE]; // R18
      end else if (idx == `CSP_IDX_MODE) begin
        csrc_ff <= dat_i[`CSP_MODE_CSRC_HI:`CSP_MODE_CSRC_LO];
        sample_edge_ff <= dat_i[`CSP_MODE_SAMPLE_EDGE];
        bit_order_ff <= dat_i[`CSP_MODE_BIT_ORDER]; // R20
      end else if (idx == `CSP_IDX_IRQ_MASK) begin
        mask_ff <= dat_i[0]; // R11
      end
    end
  end

  // Clock source; the slave mode takes the synchronised pin
  assign master = (csrc_ff != `CSP_CSRC_SLAVE); // R19

  // Half-period tick: osc every pulse, osc/2 every second, timer each underflow
  assign tick = (csrc_ff == `CSP_CSRC_OSC) ? osc_tick :
    (csrc_ff == `CSP_CSRC_OSC_HALF) ? (osc_tick & half_ff) :
    (csrc_ff == `CSP_CSRC_TIMER) ? timer_underflow_i : 1'b0; // R19

  // Master clock level toggles only while a transfer runs
  always @(posedge clk_i) begin
    if (reset_i) begin
      mlvl_ff <= IDLE_LVL;
      half_ff <= 1'b0;
    end else begin
      if (osc_tick) begin
        half_ff <= ~half_ff;
      end
      if (!run_ff) begin
        mlvl_ff <= IDLE_LVL;
      end else if (tick) begin
        mlvl_ff <= ~mlvl_ff; // R1
      end
    end
  end

  // Edge detection on the working clock level, flagged in the cycle the level changes in both modes.
  // The pin synchroniser clears to zero while the idle level may be one, so
  // a false edge can follow reset; gating every edge with the run latch
  // keeps it from counting, since no trigger can land that early.
  assign lvl = master ? mlvl_ff : pins_s[1];
  always @(posedge clk_i) begin
    if (reset_i) begin
      lvl_d_ff <= IDLE_LVL;
    end else begin
      lvl_d_ff <= lvl;
    end
  end

  // Lead edge leaves the idle level, trail edge returns to it
  assign lead = run_ff & (lvl != lvl_d_ff) & (lvl_d_ff == IDLE_LVL); // R21
  assign trail = run_ff & (lvl != lvl_d_ff) & (lvl == IDLE_LVL);
  // Sample edge: phase bit picks the lead edge, else the trail edge
  assign samp = sample_edge_ff ? lead : trail; // R21
  assign last = trail & (cnt_ff == `CSP_BITS - 4'h1); // R22

  // Run latch, bit counter and receive shift register
  always @(posedge clk_i) begin
    if (reset_i) begin
      run_ff <= 1'b0; // R6
      cnt_ff <= 4'h0;
      rx_ff <= 8'h00;
    end else begin
      if (trig) begin
        run_ff <= 1'b1; // R1
        cnt_ff <= 4'h0;
      end else if (last) begin
        run_ff <= 1'b0; // R5
      end else if (trail) begin
        cnt_ff <= cnt_ff + 4'h1; // R22
      end
      // MSB first fills from bit zero upward, LSB first from bit seven down
      if (samp) begin
        if (bit_order_ff) begin
          rx_ff <= {rx_ff[6:0], pins_s[0]}; // R8
        end else begin
          rx_ff <= {pins_s[0], rx_ff[7:1]}; // R8
        end
      end
    end
  end

  // Data register has no reset on purpose; software must load it first
  always @(posedge clk_i) begin
    if (last) begin
      data_ff <= samp ? (bit_order_ff ? {rx_ff[6:0], pins_s[0]}
        : {pins_s[0], rx_ff[7:1]}) : rx_ff; // R8 R10
    end else if (wr & ~run_ff & (idx == `CSP_IDX_DATA_LO)) begin
      data_ff[3:0] <= dat_i[3:0];
    end else if (wr & ~run_ff & (idx == `CSP_IDX_DATA_HI)) begin
      data_ff[7:4] <= dat_i[3:0];
    end
  end

  // Output bit is presented at trigger and moves on each lead edge
  always @(posedge clk_i) begin
    if (reset_i) begin
      serial_out_pin_ff <= 1'b0;
    end else if (trig) begin
      serial_out_pin_ff <= data_ff[bit_idx(bit_order_ff, 4'h0)]; // R7
    end else if (lead) begin
      serial_out_pin_ff <= data_ff[bit_idx(bit_order_ff, cnt_ff)]; // R7 R21
    end
  end

  // Factor flag: a set in the same cycle as a clear wins
  // A late clear from software must never swallow a finished transfer
  always @(posedge clk_i) begin
    if (reset_i) begin
      factor_ff <= `CSP_RST_FLAG; // R13
    end else if (last) begin
      factor_ff <= 1'b1; // R12
    end else if (wr & (idx == `CSP_IDX_IRQ_FACTOR) & dat_i[0]) begin
      factor_ff <= 1'b0; // R13
    end
  end

  // Level request, so it is seen again while the flag stays set
  assign serial_irq_o = factor_ff & mask_ff; // R14

  // Pin hand-over; ready is low while a slave transfer waits for clocks
  assign port_function_enable_o = enable_ff; // R18
  assign serial_out_pin_o = serial_out_pin_ff;
  assign sclk_o = mlvl_ff;
  assign sclk_oe_o = enable_ff & master; // R18
  assign slave_ready_n_o = ~(enable_ff & ~master & run_ff); // R18
endmodule // csp_core
`default_nettype wire

// ===== bench/csp_core_chk.sv
// Checker on the serial port core pins and register bus
`timescale 1ns/1ps
`default_nettype none
module csp_core_chk #(
  parameter CLK_POS_POLARITY = 0
) (
  input wire clk_i,
  input wire reset_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [17:0] adr_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire sclk_o,
  input wire sclk_oe_o,
  input wire slave_ready_n_o,
  input wire port_function_enable_o,
  input wire serial_irq_o
);
  // Decoded bus phases; a write lands at the edge that samples ack
  wire [15:0] idx = adr_i[17:2];
  wire req = cyc_i && stb_i && !ack_o;
  wire wr = cyc_i && stb_i && we_i && ack_o;
  wire trg = wr && idx == 16'hFF70 && dat_i[1];
  wire idle = (CLK_POS_POLARITY == 0);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_ack_once; ack_o |=> !ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_ack_next; req |=> ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_unmapped;
    req && !we_i && !(idx inside {16'hFF70, 16'hFF71, 16'hFF72,
      16'hFF73, 16'hFFE3, 16'hFFF3}) |=> dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not 0");
  property p_irq_hold;
    $fell(serial_irq_o) |-> $past(wr && (idx == 16'hFFE3 ||
      (idx == 16'hFFF3 && dat_i[0])));
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  property p_oe_en; sclk_oe_o |-> port_function_enable_o; endproperty
  a_oe_en: assert property (p_oe_en) else $error("clock driven off");
  property p_rdy;
    !slave_ready_n_o |-> port_function_enable_o && !sclk_oe_o;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready in master");
  property p_idle; !port_function_enable_o |-> sclk_o == idle; endproperty
  a_idle: assert property (p_idle) else $error("clock not idle");
  property p_trg_m; trg && sclk_oe_o |-> ##[1:40] sclk_o != idle; endproperty
  a_trg_m: assert property (p_trg_m) else $error("no master clock");
  property p_trg_s;
    trg && port_function_enable_o && !sclk_oe_o |=> ##[0:2] !slave_ready_n_o;
  endproperty
  a_trg_s: assert property (p_trg_s) else $error("no ready");
endmodule // csp_core_chk
bind csp_core csp_core_chk #(.CLK_POS_POLARITY(CLK_POS_POLARITY)) u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .slave_ready_n_o(slave_ready_n_o),
  .port_function_enable_o(port_function_enable_o),
  .serial_irq_o(serial_irq_o));
`default_nettype wire

// ===== bench/csp_peer.sv
// Model of the external synchronous serial partner
`timescale 1ns/1ps
`default_nettype none
module csp_peer (
  input wire logic clk_i,
  input wire logic core_sclk_i,
  input wire logic core_sclk_oe_i,
  input wire logic core_serial_out_pin_i,
  output var logic sin_o,
  output var logic ext_sclk_o
);
  logic [7:0] tx_ff, rx_ff;
  logic msb_ff, ph_ff;
  logic [3:0] k_ff = 4'h0;
  // Clock seen on the wire; idle high, lead edge falls
  wire line = core_sclk_oe_i ? core_sclk_i : ext_sclk_o;
  wire [2:0] pos = msb_ff ? 3'h7 - k_ff[2:0] : k_ff[2:0];
  wire [2:0] pnx = msb_ff ? 3'h6 - k_ff[2:0] : k_ff[2:0] + 3'h1;
  initial begin
    sin_o = 1'h1;
    ext_sclk_o = 1'h1;
  end
  // Data moves on the edge the core does not sample, so it is settled there
  always @(negedge line) begin
    if (!ph_ff) sin_o <= tx_ff[pos];
  end
  always @(posedge line) begin
    rx_ff[pos] <= core_serial_out_pin_i;
    k_ff <= k_ff + 4'h1;
    if (ph_ff) sin_o <= tx_ff[pnx];
  end
  task arm(input logic [7:0] tx, input logic m, input logic p);
    @(posedge clk_i);
    tx_ff <= tx;
    msb_ff <= m;
    ph_ff <= p;
    k_ff <= 4'h0;
    sin_o <= m ? tx[7] : tx[0];
  endtask
  // Called only after the trigger; 63-cycle halves keep it under 1 MHz
  task clk_out(input integer half);
    integer j;
    for (j = 0; j < 16; j++) begin
      repeat (half) @(posedge clk_i);
      ext_sclk_o <= ~ext_sclk_o;
    end
  endtask
endmodule // csp_peer
`default_nettype wire

// ===== bench/tb_csp_core.sv
// Self-checking bench for the clocked serial port core
`timescale 1ns/1ps
`default_nettype none
`include "csp_defines.vh"
module tb_csp_core;
  logic clk_i, reset_i, cyc_i, stb_i, we_i, tmr;
  logic [17:0] adr_i;
  logic [31:0] dat_i, q;
  logic [18:0] r;
  wire [31:0] dat_o;
  wire ack_o, serial_out_pin, sclk_o, oe, rdy_n, pfe, irq, serial_in_pin, xclk;
  integer n_mismatch = 0, n_checks = 0, cnt = 0, i, t;
  // Rows: clock source, msb first, core byte, partner byte; odd rows sample
  // on the lead edge and unmask the interrupt
  logic [18:0] rows [4] = '{{2'h3, 1'h1, 8'hA6, 8'h3D},
    {2'h2, 1'h0, 8'h83, 8'hC4}, {2'h1, 1'h1, 8'h1E, 8'h01},
    {2'h0, 1'h0, 8'h6C, 8'hF0}};
  csp_core #(.OSC_HALF_DIV(4)) u_csp_core (.clk_i(clk_i), .reset_i(reset_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .timer_underflow_i(tmr), .serial_in_pin_i(serial_in_pin), .serial_out_pin_o(serial_out_pin),
    .sclk_i(xclk), .sclk_o(sclk_o), .sclk_oe_o(oe), .slave_ready_n_o(rdy_n),
    .port_function_enable_o(pfe), .serial_irq_o(irq));
  csp_peer u_csp_peer (.clk_i(clk_i), .core_sclk_i(sclk_o),
    .core_sclk_oe_i(oe), .core_serial_out_pin_i(serial_out_pin), .sin_o(serial_in_pin), .ext_sclk_o(xclk));
  initial begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end
  // Timer underflow every 8 cycles; hang guard well above the run length
  always @(posedge clk_i) begin
    tmr <= (cnt % 8 == 7);
    cnt <= cnt + 1;
    if (cnt == 20000) begin
      n_mismatch++;
      conclude;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic single cycle; held until ack is sampled high
  task wb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    integer n;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, idx, 2'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'h1 && n < 20);
    if (n == 20) n_mismatch++;
    q = dat_o;
    {cyc_i, stb_i} <= 2'h0;
  endtask
  task conclude;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    {reset_i, cyc_i, stb_i, we_i, adr_i, dat_i} = {4'h8, 18'h0, 32'h0};
    repeat (4) @(posedge clk_i);
    reset_i <= 1'h0;
    wb(0, `CSP_IDX_CTRL, 0); chk(q, 0);
    wb(0, `CSP_IDX_MODE, 0); chk(q, 0);
    wb(0, `CSP_IDX_IRQ_MASK, 0); chk(q, 0);
    wb(0, `CSP_IDX_IRQ_FACTOR, 0); chk(q, 0);
    chk({rdy_n, pfe, oe, irq}, 4'h8);
    wb(0, 16'hFF74, 0); chk(q, 0);
    wb(1, `CSP_IDX_CTRL, 1); wb(0, `CSP_IDX_CTRL, 0); chk(q, 1);
    for (i = 0; i < 4; i++) begin
      r = rows[i];
      wb(1, `CSP_IDX_IRQ_MASK, i % 2);
      wb(1, `CSP_IDX_MODE, {r[16], i[0], r[18:17]});
      wb(0, `CSP_IDX_MODE, 0); chk(q, {r[16], i[0], r[18:17]});
      wb(1, `CSP_IDX_DATA_LO, r[11:8]);
      wb(1, `CSP_IDX_DATA_HI, r[15:12]);
      u_csp_peer.arm(r[7:0], r[16], i[0]);
      wb(1, `CSP_IDX_CTRL, 3);
      wb(0, `CSP_IDX_CTRL, 0); chk(q[1], 1);
      if (r[18:17] == 2'h0) begin
        chk(rdy_n, 0);
        u_csp_peer.clk_out(63);
      end
      t = 0;
      do begin
        wb(0, `CSP_IDX_CTRL, 0);
        t++;
      end while (q[1] !== 1'h0 && t < 600);
      chk(q[1], 0);
      chk(irq, i % 2);
      wb(0, `CSP_IDX_DATA_LO, 0); chk(q, r[3:0]);
      wb(0, `CSP_IDX_DATA_HI, 0); chk(q, r[7:4]);
      chk(u_csp_peer.rx_ff, r[15:8]);
      wb(1, `CSP_IDX_IRQ_FACTOR, 0);
      wb(0, `CSP_IDX_IRQ_FACTOR, 0); chk(q, 1);
      wb(1, `CSP_IDX_IRQ_FACTOR, 1);
      wb(0, `CSP_IDX_IRQ_FACTOR, 0); chk(q, 0);
      chk(irq, 0);
    end
    // Reset in mid-run, slave waiting for a clock that never comes
    wb(1, `CSP_IDX_CTRL, 3);
    reset_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'h0;
    wb(0, `CSP_IDX_CTRL, 0); chk(q, 0);
    chk({rdy_n, pfe}, 2'h2);
    conclude;
  end
endmodule // tb_csp_core
`default_nettype wire
